/* atri_consts.vh */
// Purpose: Constants for the asynchronous timer register block.
// Assumes: Eight-bit register port with a four-bit word address.
// Notes: Offsets are word indices on the plain register port.
`ifndef ATRI_CONSTS_VH
`define ATRI_CONSTS_VH
// Register offsets.
`define ATRI_OFF_CNT 4'h0
`define ATRI_OFF_CMPA 4'h1
`define ATRI_OFF_CMPB 4'h2
`define ATRI_OFF_CTLA 4'h3
`define ATRI_OFF_CTLB 4'h4
`define ATRI_OFF_ASTAT 4'h5
`define ATRI_OFF_MASK 4'h6
`define ATRI_OFF_FLAGS 4'h7
`define ATRI_OFF_GEN 4'h8
// Async status fields.
`define ATRI_BIT_EXTCLK 6
`define ATRI_BIT_ASYNC 5
`define ATRI_UB_CNT 4
`define ATRI_UB_CMPA 3
`define ATRI_UB_CMPB 2
`define ATRI_UB_CTLA 1
`define ATRI_UB_CTLB 0
// Interrupt mask and flag fields.
`define ATRI_IRQ_CMPB 2
`define ATRI_IRQ_CMPA 1
`define ATRI_IRQ_OVF 0
// General control fields.
`define ATRI_BIT_HOLD 7
`define ATRI_BIT_PSR 1
// Control register fields and read masks.
`define ATRI_CTLA_RDMASK 8'hf3
`define ATRI_CTLB_RDMASK 8'h0f
`define ATRI_BIT_FOCA 7
`define ATRI_BIT_FOCB 6
`define ATRI_BIT_WGM2 3
// Clock select codes.
`define ATRI_CS_DIV1 3'h1
`define ATRI_CS_DIV8 3'h2
`define ATRI_CS_DIV32 3'h3
`define ATRI_CS_DIV64 3'h5
// Prescaler terminal counts.
`define ATRI_PS_MAX8 3'h7
`define ATRI_PS_MAX32 5'h1f
`define ATRI_PS_MAX64 6'h3f
// Counter limits and modes.
`define ATRI_MAX 8'hff
`define ATRI_BOTTOM 8'h00
`define ATRI_MODE_PC 3'h1
`define ATRI_MODE_CTC 3'h2
`define ATRI_MODE_PCA 3'h5
`define ATRI_MODE_FPA 3'h7
// Reset values.
`define ATRI_RST_BYTE 8'h00
`endif

/* atri_timer.v */
// Purpose: Eight-bit timer with compare units, async clock option and busy flags.
// Assumes: All inputs synchronous to clk_sys_i; oscillator pin is sampled.
// Notes: Async mode ticks on rising edges of the sampled oscillator pin.
`timescale 1ns/1ps
`default_nettype none
`include "atri_consts.vh"

// Behaviour
// - Counter readable directly; writable directly when synchronous, through a temporary in async mode.
// - Counter write blocks next compare match.
// - Two compare values checked against count continuously.
// - External buffer enable; crystal runs when clear in async mode.
// - Select bit picks io clock or oscillator.
// - Switching clock source may corrupt registers.
// - Async writes to counter, compare and control registers set busy until transferred.
// - Counter and status, mask, flag and general registers read live; compare and control registers read temporaries.
// - Mask bits gate flags with global enable.
// - Compare match sets its compare flag.
// - Overflow flag; phase-correct PWM sets it at bottom.
// - Flags cleared by vector or writing one.
// - Prescaler reset bit self-clears when synchronous.
// - Async prescaler reset holds until done.
// - Hold bit keeps prescaler reset set.
module atri_timer (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire osc_input_pin_i,
  input wire global_irq_enable_i,
  input wire [2:0] vector_ack_i,
  output reg compare_a_output_o,
  output reg compare_b_output_o,
  output wire xtal_osc_run_o,
  output wire ext_clk_buf_en_o,
  output wire irq_o
);

  reg [7:0] counter_value;
  reg [7:0] cmp_a;
  reg [7:0] cmp_b;
  reg [7:0] ctl_a;
  reg [7:0] ctl_b;
  reg [7:0] tmp_cnt;
  reg [7:0] tmp_a;
  reg [7:0] tmp_b;
  reg [7:0] tmp_ca;
  reg [7:0] tmp_cb;
  reg ext_en;
  reg as_sel;
  reg [4:0] busy;
  reg [2:0] irq_mask;
  reg [2:0] flags;
  reg hold;
  reg psr;
  reg [5:0] presc;
  reg down;
  reg blk;
  reg osc_s1;
  reg osc_s2;
  reg osc_s3;

  ////////////////////////////////////////////////////////////////////
  // Register port decode.
  wire wr_cnt = wr_i && (addr_i == `ATRI_OFF_CNT);
  wire wr_a = wr_i && (addr_i == `ATRI_OFF_CMPA);
  wire wr_b = wr_i && (addr_i == `ATRI_OFF_CMPB);
  wire wr_ca = wr_i && (addr_i == `ATRI_OFF_CTLA);
  wire wr_cb = wr_i && (addr_i == `ATRI_OFF_CTLB);
  wire wr_st = wr_i && (addr_i == `ATRI_OFF_ASTAT);
  wire wr_mk = wr_i && (addr_i == `ATRI_OFF_MASK);
  wire wr_fl = wr_i && (addr_i == `ATRI_OFF_FLAGS);
  wire wr_gn = wr_i && (addr_i == `ATRI_OFF_GEN);

  ////////////////////////////////////////////////////////////////////
  // Oscillator pin sampling; only the second and third stages are looked at.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_input_pin_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Source tick: every cycle for io clock, oscillator edge when async.
  wire osc_edge = osc_s2 & ~osc_s3;
  wire src_tick = as_sel ? osc_edge : 1'b1;

  // Crystal only runs with the external buffer off.
  assign ext_clk_buf_en_o = as_sel & ext_en;
  assign xtal_osc_run_o = as_sel & ~ext_en;

  ////////////////////////////////////////////////////////////////////
  // Prescaler and clock select. A held reset keeps the divider at zero.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc <= 6'h00;
    end else if (psr) begin
      presc <= 6'h00;
    end else if (src_tick) begin
      presc <= presc + 6'h01;
    end
  end

  reg tick;
  always @* begin
    tick = 1'b0;
    case (ctl_b[2:0])
      `ATRI_CS_DIV1: begin
        tick = src_tick;
      end
      `ATRI_CS_DIV8: begin
        tick = src_tick && !psr && (presc[2:0] == `ATRI_PS_MAX8);
      end
      `ATRI_CS_DIV32: begin
        tick = src_tick && !psr && (presc[4:0] == `ATRI_PS_MAX32);
      end
      `ATRI_CS_DIV64: begin
        tick = src_tick && !psr && (presc == `ATRI_PS_MAX64);
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Mode decode from the two control registers.
  wire [2:0] mode = {ctl_b[`ATRI_BIT_WGM2], ctl_a[1:0]};
  wire phase = (mode == `ATRI_MODE_PC) || (mode == `ATRI_MODE_PCA);
  wire fast = (ctl_a[1:0] == 2'h3);
  wire pwm = phase | fast;
  wire top_a = (mode == `ATRI_MODE_CTC) || (mode == `ATRI_MODE_PCA) || (mode == `ATRI_MODE_FPA);
  wire [7:0] top = top_a ? cmp_a : `ATRI_MAX;
  wire at_top = (counter_value == top);

  // Compare matches, blocked on the tick right after a counter load.
  wire match_a = tick && !blk && (counter_value == cmp_a);
  wire match_b = tick && !blk && (counter_value == cmp_b);

  // Overflow: wrap at MAX, at TOP in mode 7, at bottom turn in phase modes.
  reg ovf;
  always @* begin
    ovf = 1'b0;
    if (phase) begin
      ovf = tick && down && (counter_value == `ATRI_BOTTOM);
    end else if (mode == `ATRI_MODE_FPA) begin
      ovf = tick && at_top;
    end else begin
      ovf = tick && (counter_value == `ATRI_MAX);
    end
  end

  // Async transfers happen on the next source tick after the write.
  wire xfer = as_sel & src_tick;
  wire load_cnt_async = xfer & busy[`ATRI_UB_CNT];
  wire load_cnt = (wr_cnt & ~as_sel) | load_cnt_async;
  wire [7:0] load_val = as_sel ? tmp_cnt : wdata_i;

  ////////////////////////////////////////////////////////////////////
  // Counter and direction. A load wins over counting.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      counter_value <= `ATRI_RST_BYTE;
      down <= 1'b0;
      blk <= 1'b0;
    end else begin
      if (load_cnt) begin
        counter_value <= load_val;
        blk <= 1'b1;
      end else if (tick) begin
        blk <= 1'b0;
        if (phase) begin
          if (!down && at_top) begin
            down <= 1'b1;
            counter_value <= counter_value - 8'h01;
          end else if (down && counter_value == `ATRI_BOTTOM) begin
            down <= 1'b0;
            counter_value <= counter_value + 8'h01;
          end else if (down) begin
            counter_value <= counter_value - 8'h01;
          end else begin
            counter_value <= counter_value + 8'h01;
          end
        end else begin
          down <= 1'b0;
          if (at_top) begin
            counter_value <= `ATRI_BOTTOM;
          end else begin
            counter_value <= counter_value + 8'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Temporary and live copies. Synchronous writes update both at once.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmp_cnt <= `ATRI_RST_BYTE;
      tmp_a <= `ATRI_RST_BYTE;
      tmp_b <= `ATRI_RST_BYTE;
      tmp_ca <= `ATRI_RST_BYTE;
      tmp_cb <= `ATRI_RST_BYTE;
      cmp_a <= `ATRI_RST_BYTE;
      cmp_b <= `ATRI_RST_BYTE;
      ctl_a <= `ATRI_RST_BYTE;
      ctl_b <= `ATRI_RST_BYTE;
    end else begin
      if (wr_cnt) begin
        tmp_cnt <= wdata_i;
      end
      if (wr_a) begin
        tmp_a <= wdata_i;
      end
      if (wr_b) begin
        tmp_b <= wdata_i;
      end
      if (wr_ca) begin
        tmp_ca <= wdata_i & `ATRI_CTLA_RDMASK;
      end
      if (wr_cb) begin
        tmp_cb <= wdata_i & `ATRI_CTLB_RDMASK;
      end
      // Live copies: direct when synchronous, from temporaries when async.
      if (wr_a && !as_sel) begin
        cmp_a <= wdata_i;
      end else if (xfer && busy[`ATRI_UB_CMPA]) begin
        cmp_a <= tmp_a;
      end
      if (wr_b && !as_sel) begin
        cmp_b <= wdata_i;
      end else if (xfer && busy[`ATRI_UB_CMPB]) begin
        cmp_b <= tmp_b;
      end
      if (wr_ca && !as_sel) begin
        ctl_a <= wdata_i & `ATRI_CTLA_RDMASK;
      end else if (xfer && busy[`ATRI_UB_CTLA]) begin
        ctl_a <= tmp_ca;
      end
      if (wr_cb && !as_sel) begin
        ctl_b <= wdata_i & `ATRI_CTLB_RDMASK;
      end else if (xfer && busy[`ATRI_UB_CTLB]) begin
        ctl_b <= tmp_cb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Busy flags clear on any source tick, so a switch to the io clock cannot strand them.
  wire [4:0] busy_set = {wr_cnt, wr_a, wr_b, wr_ca, wr_cb} & {5{as_sel}};
  wire [4:0] busy_clr = src_tick ? busy : 5'h00;

  // Async status and general control. Changing the select bit does not
  // protect the timer registers; software reloads them afterwards.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 5'h00;
      ext_en <= 1'b0;
      as_sel <= 1'b0;
      irq_mask <= 3'h0;
      hold <= 1'b0;
      psr <= 1'b0;
    end else begin
      busy <= (busy & ~busy_clr) | busy_set;
      if (wr_st) begin
        ext_en <= wdata_i[`ATRI_BIT_EXTCLK];
        as_sel <= wdata_i[`ATRI_BIT_ASYNC];
      end
      if (wr_mk) begin
        irq_mask <= wdata_i[2:0];
      end
      if (wr_gn) begin
        hold <= wdata_i[`ATRI_BIT_HOLD];
      end
      // Reset request: set by a written one; cleared once taken, never
      // while hold is set. Async mode waits for an oscillator edge.
      if (wr_gn && wdata_i[`ATRI_BIT_PSR]) begin
        psr <= 1'b1;
      end else if (psr && !hold && src_tick) begin
        psr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over a clear in the same cycle.
  wire [2:0] flag_set = {match_b, match_a, ovf};
  wire [2:0] flag_clr = (wr_fl ? wdata_i[2:0] : 3'h0) | vector_ack_i;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // Level interrupt needs enable, global bit and flag together.
  assign irq_o = global_irq_enable_i & (|(flags & irq_mask));

  ////////////////////////////////////////////////////////////////////
  // Waveform outputs. Force strobes act only in non-PWM modes and raise
  // no flag, so they feed the pin logic alone.
  wire foc_a = wr_cb && wdata_i[`ATRI_BIT_FOCA] && !pwm;
  wire foc_b = wr_cb && wdata_i[`ATRI_BIT_FOCB] && !pwm;
  wire bottom_evt = tick && at_top && fast;

  function wave_next;
    input cur;
    input [1:0] com;
    input hit;
    input bot;
    begin
      wave_next = cur;
      if (com == 2'h0) begin
        wave_next = 1'b0;
      end else if (phase) begin
        if (hit && com[1]) begin
          wave_next = com[0] ^ down;
        end
      end else if (fast) begin
        if (hit && com[1]) begin
          wave_next = com[0];
        end else if (bot && com[1]) begin
          wave_next = ~com[0];
        end
      end else if (hit) begin
        wave_next = (com == 2'h1) ? ~cur : com[0];
      end
    end
  endfunction

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      compare_a_output_o <= 1'b0;
      compare_b_output_o <= 1'b0;
    end else begin
      compare_a_output_o <= wave_next(compare_a_output_o, ctl_a[7:6], match_a | foc_a, bottom_evt);
      compare_b_output_o <= wave_next(compare_b_output_o, ctl_a[5:4], match_b | foc_b, bottom_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe; unmapped reads return zero.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ATRI_OFF_CNT: begin
          rdata_o <= counter_value;
        end
        `ATRI_OFF_CMPA: begin
          rdata_o <= tmp_a;
        end
        `ATRI_OFF_CMPB: begin
          rdata_o <= tmp_b;
        end
        `ATRI_OFF_CTLA: begin
          rdata_o <= tmp_ca;
        end
        `ATRI_OFF_CTLB: begin
          rdata_o <= tmp_cb;
        end
        `ATRI_OFF_ASTAT: begin
          rdata_o <= {1'b0, ext_en, as_sel, busy};
        end
        `ATRI_OFF_MASK: begin
          rdata_o <= {5'h00, irq_mask};
        end
        `ATRI_OFF_FLAGS: begin
          rdata_o <= {5'h00, flags};
        end
        `ATRI_OFF_GEN: begin
          rdata_o <= {hold, 5'h00, psr, 1'b0};
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // atri_timer
`default_nettype wire

/* atri_timer_asserts.sv */
// Purpose: Port-level checks for the timer register block.
// Assumes: One clock domain and an active-low asynchronous reset.
// Notes: Shadows follow software writes so reads and pins can be predicted.
`timescale 1ns/1ps
`default_nettype none
module atri_timer_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic xtal_osc_run_o,
  input wire logic ext_clk_buf_en_o,
  input wire logic irq_o
);
  logic [2:0] mask_sh;
  logic [1:0] src_sh;
  // Shadow copies of the mask and the clock source bits, written like the real ones.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_sh <= 3'h0;
      src_sh <= 2'h0;
    end else if (wr_i && addr_i == 4'h6) begin
      mask_sh <= wdata_i[2:0];
    end else if (wr_i && addr_i == 4'h5) begin
      src_sh <= wdata_i[6:5];
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_rd(logic [3:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_src_wr;
    wr_i && addr_i == 4'h5;
  endsequence
  property p_rd_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_bad;
    rd_i && addr_i > 4'h8 |=> rdata_o == 8'h00;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not zero");
  property p_src_out;
    s_src_wr |=> ext_clk_buf_en_o == (&src_sh) && xtal_osc_run_o == (src_sh == 2'b01);
  endproperty
  a_src_out: assert property (p_src_out)
    else $error("clock source pins do not follow the status write");
  property p_osc_excl;
    !(xtal_osc_run_o && ext_clk_buf_en_o);
  endproperty
  a_osc_excl: assert property (p_osc_excl)
    else $error("crystal runs with the external buffer on");
  property p_irq_gie;
    !global_irq_enable_i |-> !irq_o;
  endproperty
  a_irq_gie: assert property (p_irq_gie)
    else $error("interrupt without global enable");
  property p_irq_mask;
    irq_o |-> mask_sh != 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with all enables clear");
  property p_mask_rd;
    s_rd(4'h6) |=> rdata_o[2:0] == mask_sh;
  endproperty
  a_mask_rd: assert property (p_mask_rd)
    else $error("mask read differs from last write");
  property p_astat_rd;
    s_rd(4'h5) |=> rdata_o[7:5] == {1'b0, src_sh};
  endproperty
  a_astat_rd: assert property (p_astat_rd)
    else $error("status read differs from clock source");
  property p_busy_sync;
    s_rd(4'h5) ##0 !src_sh[0] |=> rdata_o[4:0] == 5'h00;
  endproperty
  a_busy_sync: assert property (p_busy_sync)
    else $error("busy flag set while synchronous");
  property p_rst_out;
    $rose(nrst_i) |-> !irq_o && !xtal_osc_run_o && !ext_clk_buf_en_o;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");
endmodule // atri_timer_chk
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the timer register block.
// Assumes: A 10 MHz clock and reset held low for four cycles.
// Notes: Each scenario task drives the ports and judges the answers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i, nrst_i, wr_i, rd_i, osc_input_pin_i, global_irq_enable_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [2:0] vector_ack_i;
  logic [7:0] rv;
  wire [7:0] rdata_o;
  wire compare_a_output_o, compare_b_output_o, xtal_osc_run_o, ext_clk_buf_en_o, irq_o;
  int mismatches, cmp_count;
  atri_timer atri_timer_i (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .osc_input_pin_i, .global_irq_enable_i, .vector_ack_i, .compare_a_output_o,
    .compare_b_output_o, .xtal_osc_run_o, .ext_clk_buf_en_o, .irq_o);
  // Free-running system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////
  // Bus and compare helpers; the read data is taken in the cycle after the strobe.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask
  // Pins are looked at mid-cycle so the last write has landed.
  task automatic pins(input logic [7:0] e);
    @(negedge clk_sys_i);
    chk({3'h0, compare_b_output_o, compare_a_output_o, irq_o, ext_clk_buf_en_o, xtal_osc_run_o}, e);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int a = 5; a < 9; a++) rchk(a[3:0], 8'h00);
    pins(8'h00);
    wr(4'hf, 8'hff);
    rchk(4'hf, 8'h00);
  endtask
  task automatic t_count;
    logic [7:0] c0;
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h5a);
    rchk(4'h0, 8'h5a);
    wr(4'h4, 8'h01);
    rd(4'h0, c0);
    rchk(4'h0, c0 + 8'h02);
    wr(4'h4, 8'h00);
  endtask
  // Runs through overflow and both compares, then clears flags both ways.
  task automatic t_irq;
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h05);
    wr(4'h0, 8'hfe);
    wr(4'h7, 8'h07);
    wr(4'h6, 8'h07);
    global_irq_enable_i <= 1'b1;
    wr(4'h4, 8'h01);
    repeat (10) @(posedge clk_sys_i);
    wr(4'h4, 8'h00);
    rchk(4'h7, 8'h07);
    pins(8'h04);
    @(posedge clk_sys_i);
    vector_ack_i <= 3'h2;
    @(posedge clk_sys_i);
    vector_ack_i <= 3'h0;
    rchk(4'h7, 8'h05);
    wr(4'h7, 8'h01);
    rchk(4'h7, 8'h04);
    wr(4'h6, 8'h03);
    pins(8'h00);
    wr(4'h6, 8'h04);
    rchk(4'h6, 8'h04);
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b0;
    pins(8'h00);
    wr(4'h7, 8'h04);
    global_irq_enable_i <= 1'b1;
  endtask
  // A counter write landing on the compare value must not raise the flag.
  task automatic t_block;
    wr(4'h7, 8'h07);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h03);
    wr(4'h4, 8'h00);
    rchk(4'h7, 8'h00);
  endtask
  // Oscillator pin held still so writes wait in temporary storage.
  task automatic t_async;
    wr(4'h0, 8'h11);
    wr(4'h5, 8'h60);
    pins(8'h02);
    wr(4'h5, 8'h20);
    pins(8'h01);
    wr(4'h0, 8'h40);
    wr(4'h1, 8'h77);
    wr(4'h8, 8'h02);
    rchk(4'h5, 8'h38);
    rchk(4'h0, 8'h11);
    rchk(4'h1, 8'h77);
    rchk(4'h8, 8'h02);
    @(posedge clk_sys_i);
    osc_input_pin_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    osc_input_pin_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rchk(4'h5, 8'h20);
    rchk(4'h0, 8'h40);
    rchk(4'h8, 8'h00);
    wr(4'h5, 8'h00);
    pins(8'h00);
  endtask
  task automatic t_psr;
    wr(4'h8, 8'h82);
    repeat (3) @(posedge clk_sys_i);
    rchk(4'h8, 8'h82);
    wr(4'h8, 8'h00);
    wr(4'h8, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    rchk(4'h8, 8'h00);
  endtask
  // Phase-correct counting with its top at compare A, then force strobes set and clear pin B.
  task automatic t_wave;
    wr(4'h7, 8'h07);
    wr(4'h1, 8'h04);
    wr(4'h3, 8'hc1);
    wr(4'h0, 8'h02);
    wr(4'h4, 8'h09);
    repeat (3) @(posedge clk_sys_i);
    rchk(4'h0, 8'h02);
    rchk(4'h7, 8'h02);
    rchk(4'h7, 8'h03);
    wr(4'h4, 8'h00);
    pins(8'h08);
    wr(4'h3, 8'h30);
    wr(4'h4, 8'hc0);
    pins(8'h10);
    wr(4'h3, 8'h20);
    wr(4'h4, 8'h40);
    pins(8'h00);
    wr(4'h7, 8'h07);
  endtask
  ////////////////////////////////////////
  task automatic test_done;
    $display("TB: %0d mismatches, %0d comparisons", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence; every input gets a value at time zero.
  initial begin
    mismatches = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    osc_input_pin_i = 1'b0;
    global_irq_enable_i = 1'b0;
    vector_ack_i = 3'h0;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset();
    t_count();
    t_irq();
    t_block();
    t_async();
    t_psr();
    t_wave();
    test_done();
  end
  // The tests need a few hundred cycles; this cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    mismatches++;
    test_done();
  end
endmodule // tb
bind atri_timer atri_timer_chk atri_timer_chk_i (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .global_irq_enable_i, .xtal_osc_run_o, .ext_clk_buf_en_o, .irq_o);
`default_nettype wire
